// ---- logic/ptp_consts.vh ----
// constants for the proximity threshold and persistence block
// assumes a byte-wide register port driven by the two-wire bus engine
// Overview of operation
// - sample lasts (rate+1) times 88 us
// - apc on: low threshold is 14 bits
// - apc on: high threshold is 14 bits
// - apc off: low byte vs result bits 9:2
// - apc off: high byte vs result bits 9:2
// - low breach needs below-low and persistence reached
// - high breach needs above-high and persistence reached
// - apc on: low byte buffered until upper byte written
// - config six bit 6 disables apc
// - count out-of-range results, interrupt at persistence
// - in-window result clears the counter
// - 0 every cycle, 1 first of a run, n consecutive
// - detect only with enable bits 2 and 0
`ifndef PTP_CONSTS_VH
`define PTP_CONSTS_VH

// register offsets
`define PTP_ADDR_ENABLE       8'h80
`define PTP_ADDR_SAMPLE_RATE  8'h82
`define PTP_ADDR_LOW_LO       8'h88
`define PTP_ADDR_LOW_HI       8'h89
`define PTP_ADDR_HIGH_LO      8'h8A
`define PTP_ADDR_HIGH_HI      8'h8B
`define PTP_ADDR_PERSIST      8'h8C
`define PTP_ADDR_CONFIG_SIX   8'hAE

// reset values
`define PTP_RST_ENABLE        8'h00
`define PTP_RST_SAMPLE_RATE   8'h1F
`define PTP_RST_THRESH        8'h00
`define PTP_RST_PERSIST       8'h00
`define PTP_RST_CONFIG_SIX    8'h3F
`define PTP_RST_ZERO14        14'h0000
`define PTP_RST_COUNT         4'h0
`define PTP_READ_UNMAPPED     8'h00

// field positions
`define PTP_BIT_POWER_ON      0
`define PTP_BIT_PROX_ENABLE   2
`define PTP_BIT_APC_OFF       6
`define PTP_THR_HI_MSB        5
`define PTP_PERSISTENCE_FILTER_MSB          3
`define PTP_RES10_MSB         9
`define PTP_RES10_LSB         2

// persistence codes
`define PTP_PERSISTENCE_FILTER_EVERY        4'h0
`define PTP_PERSISTENCE_FILTER_MAX          4'hF

// sample timing
`define PTP_CLK_PERIOD_NS     25
`define PTP_SAMPLE_UNIT_NS    88000
`define PTP_UNIT_CYCLES       (`PTP_SAMPLE_UNIT_NS / `PTP_CLK_PERIOD_NS)

`endif

// ---- logic/ptp_sample_timer.v ----
// sample period timer: one start pulse per proximity sample
// assumes run_in and rate_in come from the same clock domain
`timescale 1ns/1ps
`include "ptp_consts.vh"
module ptp_sample_timer #(
	parameter UNIT_CYCLES = `PTP_UNIT_CYCLES // cycles in one 88 us unit
)(
	input  wire       clk_sys_in,   // system clock, 40 MHz
	input  wire       rst_in,       // synchronous reset, active high
	input  wire       run_in,       // timer runs while high
	input  wire [7:0] rate_in,      // sample rate field
	output reg        tick_out      // one-cycle pulse at sample start
);
	localparam integer UNIT_LAST = UNIT_CYCLES - 1; // last cycle of a unit

	reg [11:0] unit_cnt;  // cycles within a unit
	reg [7:0]  rate_cnt;  // units within a sample

	// count units, then samples of (rate+1) units
	always @(posedge clk_sys_in)
	begin
		if (rst_in || !run_in)
		begin
			unit_cnt <= 12'h000;
			rate_cnt <= 8'h00;
			tick_out <= 1'b0;
		end
		else if (unit_cnt == UNIT_LAST[11:0])
		begin
			unit_cnt <= 12'h000;
			if (rate_cnt >= rate_in) // (rate+1) units elapsed
			begin
				rate_cnt <= 8'h00;
				tick_out <= 1'b1;
			end
			else
			begin
				rate_cnt <= rate_cnt + 8'h01;
				tick_out <= 1'b0;
			end
		end
		else
		begin
			unit_cnt <= unit_cnt + 12'h001;
			tick_out <= 1'b0;
		end
	end
endmodule

// ---- logic/ptp_core.v ----
// proximity threshold compare and persistence filter with its registers
// assumes a byte register port behind the bus engine and a result strobe
// from the converter, both on clk_sys_in
`timescale 1ns/1ps
`include "ptp_consts.vh"
module ptp_core #(
	parameter UNIT_CYCLES = `PTP_UNIT_CYCLES // cycles per 88 us unit
)(
	input  wire        clk_sys_in,      // system clock, 40 MHz
	input  wire        rst_in,          // synchronous reset, active high
	input  wire [7:0]  reg_addr_in,     // register address
	input  wire [7:0]  reg_wdata_in,    // write data
	input  wire        reg_wr_in,       // write strobe, one cycle
	input  wire        reg_rd_in,       // read strobe, one cycle
	input  wire [13:0] result_in,       // proximity result
	input  wire        result_valid_in, // result strobe, one cycle
	output reg  [7:0]  reg_rdata_out,   // read data, valid cycle after strobe
	output reg         sample_start_out,// pulse at start of each sample
	output reg         apc_off_out,     // high: 10-bit results wanted
	output reg         prox_int_out,    // interrupt pulse
	output reg         low_breach_out,  // low threshold breached pulse
	output reg         high_breach_out  // high threshold breached pulse
);
	// software registers
	reg [7:0]  enable;        // enable register
	reg [7:0]  sample_rate;   // sample rate
	reg [7:0]  low_lo;        // low threshold low byte
	reg [7:0]  low_hi;        // low threshold upper byte
	reg [7:0]  high_lo;       // high threshold low byte
	reg [7:0]  high_hi;       // high threshold upper byte
	reg [7:0]  persist;       // persistence filter
	reg [7:0]  config_six;    // config six
	// active thresholds and low-byte buffers
	reg [13:0] low_active;    // latched low threshold
	reg [13:0] high_active;   // latched high threshold
	reg [7:0]  low_buf;       // pending low byte
	reg [7:0]  high_buf;      // pending high byte
	reg [3:0]  persistence_count; // consecutive out-of-range results
	reg [3:0]  next_count;    // count after this result
	wire       run;           // detection active
	wire       tick;          // sample start from timer
	wire       apc_off;       // automatic pulse control disabled
	reg        below;         // result under low threshold
	reg        above;         // result over high threshold
	reg        reached;       // persistence reached
	reg        run_q;         // detection state one cycle ago

	// detection needs both power on and proximity enable
	assign run = enable[`PTP_BIT_POWER_ON] & enable[`PTP_BIT_PROX_ENABLE];
	assign apc_off = config_six[`PTP_BIT_APC_OFF];

	// unsigned strict compare in either result width
	function cmp_lt;
		input [13:0] a;
		input [13:0] b;
		begin
			cmp_lt = (a < b);
		end
	endfunction

	// sample period timer
	ptp_sample_timer #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_timer (
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.run_in     (run),
		.rate_in    (sample_rate),
		.tick_out   (tick)
	);

	// threshold compare and persistence arithmetic
	always @*
	begin
		if (apc_off)
		begin
			// 8-bit thresholds against upper result bits
			below = cmp_lt({6'h00, result_in[`PTP_RES10_MSB:`PTP_RES10_LSB]},
				{6'h00, low_lo});
			above = cmp_lt({6'h00, high_lo},
				{6'h00, result_in[`PTP_RES10_MSB:`PTP_RES10_LSB]});
		end
		else
		begin
			below = cmp_lt(result_in, low_active);
			above = cmp_lt(high_active, result_in);
		end
		if (!(below || above))
			next_count = `PTP_RST_COUNT; // in window clears
		else if (persistence_count == `PTP_PERSISTENCE_FILTER_MAX)
			next_count = persistence_count; // saturate
		else
			next_count = persistence_count + 4'h1;
		if (persist[`PTP_PERSISTENCE_FILTER_MSB:0] == `PTP_PERSISTENCE_FILTER_EVERY)
			reached = 1'b1; // every cycle
		else
			reached = (next_count == persist[`PTP_PERSISTENCE_FILTER_MSB:0]);
	end

	// register writes and threshold latching
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			enable      <= `PTP_RST_ENABLE;
			sample_rate <= `PTP_RST_SAMPLE_RATE;
			low_lo      <= `PTP_RST_THRESH;
			low_hi      <= `PTP_RST_THRESH;
			high_lo     <= `PTP_RST_THRESH;
			high_hi     <= `PTP_RST_THRESH;
			persist     <= `PTP_RST_PERSIST;
			config_six  <= `PTP_RST_CONFIG_SIX;
			low_active  <= `PTP_RST_ZERO14;
			high_active <= `PTP_RST_ZERO14;
			low_buf     <= `PTP_RST_THRESH;
			high_buf    <= `PTP_RST_THRESH;
			run_q       <= 1'b0;
		end
		else
		begin
			run_q <= run;
			// only the stop of detection drops a pending low byte, so a host
			// may still load thresholds while detection is off
			if (run_q && !run)
			begin
				// drop any half-written threshold
				low_buf  <= low_active[7:0];
				high_buf <= high_active[7:0];
			end
			if (reg_wr_in)
			begin
				case (reg_addr_in)
					`PTP_ADDR_ENABLE:      enable <= reg_wdata_in;
					`PTP_ADDR_SAMPLE_RATE: sample_rate <= reg_wdata_in;
					`PTP_ADDR_LOW_LO:
					begin
						low_lo  <= reg_wdata_in;
						low_buf <= reg_wdata_in; // held until upper
					end
					`PTP_ADDR_LOW_HI:
					begin
						low_hi     <= reg_wdata_in;
						// both bytes latched together
						low_active <= {reg_wdata_in[`PTP_THR_HI_MSB:0], low_buf};
					end
					`PTP_ADDR_HIGH_LO:
					begin
						high_lo  <= reg_wdata_in;
						high_buf <= reg_wdata_in; // held until upper
					end
					`PTP_ADDR_HIGH_HI:
					begin
						high_hi     <= reg_wdata_in;
						// both bytes latched together
						high_active <= {reg_wdata_in[`PTP_THR_HI_MSB:0], high_buf};
					end
					`PTP_ADDR_PERSIST:     persist <= reg_wdata_in;
					`PTP_ADDR_CONFIG_SIX:  config_six <= reg_wdata_in;
					default:               ; // unmapped writes ignored
				endcase
			end
		end
	end

	// register reads, answer one cycle after the strobe
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
			reg_rdata_out <= `PTP_READ_UNMAPPED;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				`PTP_ADDR_ENABLE:      reg_rdata_out <= enable;
				`PTP_ADDR_SAMPLE_RATE: reg_rdata_out <= sample_rate;
				`PTP_ADDR_LOW_LO:      reg_rdata_out <= low_lo;
				`PTP_ADDR_LOW_HI:      reg_rdata_out <= low_hi;
				`PTP_ADDR_HIGH_LO:     reg_rdata_out <= high_lo;
				`PTP_ADDR_HIGH_HI:     reg_rdata_out <= high_hi;
				`PTP_ADDR_PERSIST:     reg_rdata_out <= persist;
				`PTP_ADDR_CONFIG_SIX:  reg_rdata_out <= config_six;
				default:               reg_rdata_out <= `PTP_READ_UNMAPPED;
			endcase
		end
	end

	// persistence counter and event outputs
	always @(posedge clk_sys_in)
	begin
		if (rst_in || !run)
		begin
			persistence_count <= `PTP_RST_COUNT;
			prox_int_out      <= 1'b0;
			low_breach_out    <= 1'b0;
			high_breach_out   <= 1'b0;
		end
		else if (result_valid_in)
		begin
			persistence_count <= next_count;
			prox_int_out      <= reached;
			low_breach_out    <= below & reached;
			high_breach_out   <= above & reached;
		end
		else
		begin
			prox_int_out    <= 1'b0;
			low_breach_out  <= 1'b0;
			high_breach_out <= 1'b0;
		end
	end

	// timing and mode outputs from flops
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			sample_start_out <= 1'b0;
			apc_off_out      <= 1'b0;
		end
		else
		begin
			sample_start_out <= tick;
			apc_off_out      <= apc_off;
		end
	end
endmodule

// ---- bench/ptp_core_props.sv ----
// port checker for the threshold and persistence core
// assumes it is bound onto ptp_core, one clock, reset active high
`timescale 1ns/1ps
module ptp_core_props (
	input wire       clk_sys_in,
	input wire       rst_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire       reg_wr_in,
	input wire       reg_rd_in,
	input wire       result_valid_in,
	input wire [7:0] reg_rdata_out,
	input wire       sample_start_out,
	input wire       apc_off_out,
	input wire       prox_int_out,
	input wire       low_breach_out,
	input wire       high_breach_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	AST_INT_CAUSE: assert property (
		prox_int_out |-> $past(result_valid_in)) else $error("interrupt without result");
	AST_LOW_SIDE: assert property (
		low_breach_out |-> prox_int_out) else $error("low breach without interrupt");
	AST_HIGH_SIDE: assert property (
		high_breach_out |-> prox_int_out) else $error("high breach without interrupt");
	AST_ONE_SIDE: assert property (
		!(low_breach_out && high_breach_out)) else $error("both breaches at once");
	AST_START_GAP: assert property (
		sample_start_out |=> !sample_start_out [*3]) else $error("sample starts too close");
	AST_APC_SET: assert property (
		reg_wr_in && reg_addr_in == 8'hAE && reg_wdata_in[6] |-> ##2 apc_off_out)
		else $error("apc off not taken");
	AST_APC_HOLD: assert property (
		$changed(apc_off_out) |-> $past(reg_wr_in, 2)) else $error("apc off moved alone");
	AST_RD_UNMAPPED: assert property (
		reg_rd_in && reg_addr_in == 8'h81 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind ptp_core ptp_core_props props_u (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
	.reg_wr_in, .reg_rd_in, .result_valid_in, .reg_rdata_out, .sample_start_out,
	.apc_off_out, .prox_int_out, .low_breach_out, .high_breach_out);

// ---- bench/ptp_host_model.sv ----
// host model: byte register writes and reads on the core's port
// assumes strobes are sampled on the rising edge of clk_sys_in
`timescale 1ns/1ps
module ptp_host_model (
	input  wire        clk_sys_in,
	input  wire  [7:0] rdata_in,
	output logic [7:0] addr_out = 8'h00,
	output logic [7:0] wdata_out = 8'h00,
	output logic       wr_out = 1'b0,
	output logic       rd_out = 1'b0
);
	// one write strobe, data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_in) #1;
		addr_out = a;
		wdata_out = v;
		wr_out = 1'b1;
		@(posedge clk_sys_in) #1;
		wr_out = 1'b0;
		wdata_out = ~v;
	endtask
	// one read strobe, data taken in the next cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys_in) #1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_sys_in) #1;
		rd_out = 1'b0;
		v = rdata_in;
	endtask
	// low byte then upper byte, nothing between
	task automatic thr(input logic [7:0] a, input logic [13:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, {2'b00, v[13:8]}); // reserved bits kept at zero
	endtask
endmodule

// ---- bench/prox_threshold_persistence_test.sv ----
// self-checking bench for the threshold and persistence core
// assumes the host model owns the register port
`timescale 1ns/1ps
module prox_threshold_persistence_test;
	logic        clk_sys_in = 0;
	logic        rst_in = 1;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, d;
	logic        reg_wr_in, reg_rd_in, result_valid_in = 0;
	logic [13:0] result_in = 0;
	logic        sample_start_out, apc_off_out, prox_int_out, low_breach_out, high_breach_out;
	logic [31:0] seed = 32'h8A374D0E;
	int          n_errors = 0, n_tests = 0;
	int          lo, hi, persistence_filter, cnt, aoff, en, k, c, b, w; // model state
	int          pmap[5] = '{0, 1, 2, 3, 15};
	logic [7:0]  ra[6] = '{8'h82, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C};
	ptp_core #(.UNIT_CYCLES(4)) dut_u (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .result_in, .result_valid_in, .reg_rdata_out,
		.sample_start_out, .apc_off_out, .prox_int_out, .low_breach_out, .high_breach_out);
	ptp_host_model host_u (.clk_sys_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
		.wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
	initial forever #12.5 clk_sys_in = ~clk_sys_in;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one result: model first, then the pulses of the next cycle
	task automatic send(input int v);
		int s, lt, ht, ev;
		s = aoff ? v >> 2 : v;
		lt = s < (aoff ? lo % 256 : lo);
		ht = s > (aoff ? hi % 256 : hi);
		cnt = en && (lt || ht) ? (cnt < 15 ? cnt + 1 : 15) : 0;
		ev = en && (persistence_filter == 0 || (lt || ht) && cnt == persistence_filter);
		@(posedge clk_sys_in) #1;
		result_in = 14'(v);
		result_valid_in = 1;
		@(posedge clk_sys_in) #1;
		result_valid_in = 0;
		result_in = ~result_in;
		chk("prox_int", prox_int_out, ev);
		chk("low_breach", low_breach_out, ev && lt);
		chk("high_breach", high_breach_out, ev && ht);
	endtask
	// watchdog
	initial
	begin
		#500000;
		n_errors++;
		test_done();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys_in);
		#1 rst_in = 0;
		foreach (ra[i])
		begin
			host_u.rd(ra[i], d);
			chk("reset_value", d, i ? 8'h00 : 8'h1F);
		end
		host_u.rd(8'h81, d);
		chk("unmapped", d, 8'h00);
		host_u.wr(8'h82, 8'h01); // rate set before detection starts
		for (int m = 0; m < 10; m++)
		begin
			aoff = m < 5;
			persistence_filter = pmap[m % 5];
			host_u.wr(8'h80, 8'h01);
			en = 0;
			send(0); // refused while detection is off
			host_u.wr(8'hAE, aoff ? 8'h7F : 8'h3F);
			host_u.wr(8'h8C, 8'(persistence_filter));
			chk("apc_off", apc_off_out, aoff);
			b = aoff ? rnd() % 112 + 16 : rnd() % 4096 + 256;
			w = aoff ? 64 : 512;
			lo = b + (aoff ? rnd() % 64 * 256 : 0);
			hi = b + w + (aoff ? rnd() % 64 * 256 : 0);
			host_u.thr(8'h88, 14'(lo));
			host_u.thr(8'h8A, 14'(hi));
			host_u.wr(8'h80, 8'h05); // thresholds set before detection
			en = 1;
			repeat (40)
			begin
				k = rnd() % 16;
				c = (persistence_filter > 3 ? k == 0 : k > 11) ? b + rnd() % (w + 1) :
					k % 2 ? rnd() % b : b + w + 1 + rnd() % 16;
				send(aoff ? c * 4 + rnd() % 4 : c);
			end
		end
		// parked low byte must not act before its upper byte
		host_u.wr(8'h8C, 8'h01);
		persistence_filter = 1;
		host_u.wr(8'h88, 8'hFF);
		send(lo);
		host_u.rd(8'h88, d);
		chk("low_readback", d, 8'hFF);
		host_u.wr(8'h89, 8'h00);
		lo = 255;
		send(254);
		// a pending low byte and the count are dropped when detection stops
		host_u.wr(8'h88, 8'h10);
		host_u.wr(8'h80, 8'h01);
		host_u.wr(8'h80, 8'h05);
		cnt = 0;
		host_u.wr(8'h89, 8'h00);
		send(254);
		for (k = 0; k < 99 && !sample_start_out; k++) @(posedge clk_sys_in) #1;
		for (k = 1; k < 99; k++)
		begin
			@(posedge clk_sys_in) #1;
			if (sample_start_out)
				break;
		end
		chk("sample_period", k, 8);
		test_done();
	end
endmodule
